// >>> include/dtb_pkg.sv
// Constants, register map and helpers for the drop telecom bus port
package dtb_pkg;

  // ----------------------------------------
  // Structure
  // ----------------------------------------
  localparam int DTB_CHANNELS = 3;
  localparam int DTB_DATA_W = 8;
  localparam int DTB_WB_ADR_W = 12;

  // ----------------------------------------
  // Rates
  // ----------------------------------------
  // Bus clock rates in kHz
  localparam int DTB_STS3_KHZ = 19440;
  localparam int DTB_STS1_KHZ = 6480;
  // Link edges per bus clock period in STS-1 mode
  localparam int DTB_STS1_DIV = DTB_STS3_KHZ / DTB_STS1_KHZ;
  localparam logic [1:0] DTB_DIV_LAST = 2'(DTB_STS1_DIV - 1);

  // ----------------------------------------
  // Register indexes (byte address is four times the index)
  // ----------------------------------------
  localparam logic [9:0] DTB_IDX_BUS_CTRL = 10'h013B;
  localparam logic [9:0] DTB_IDX_CHAN_CFG = 10'h0140;
  localparam logic [9:0] DTB_IDX_IRQ_STAT = 10'h0141;
  localparam logic [9:0] DTB_IDX_IRQ_MASK = 10'h0142;
  localparam logic [9:0] DTB_IDX_LIVE = 10'h0143;

  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  // Bus control: parity sense and parity coverage
  localparam int DTB_CTRL_ODD_BIT = 0;
  localparam int DTB_CTRL_ALL_BIT = 1;
  localparam logic [7:0] DTB_CTRL_RESET = 8'h00;
  // Channel config: enables at [2:0], STS-1 mode at [6:4]
  localparam int DTB_CFG_EN_LSB = 0;
  localparam int DTB_CFG_STS1_LSB = 4;
  localparam logic [7:0] DTB_CFG_RESET = 8'h00;
  // Status, mask and live state: AIS field at [2:0], frame field at [6:4]
  localparam int DTB_EV_AIS_LSB = 0;
  localparam int DTB_EV_FRAME_LSB = 4;
  localparam logic [7:0] DTB_STAT_RESET = 8'h00;
  localparam logic [7:0] DTB_MASK_RESET = 8'h00;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Parity over data, or over data plus indicator and phase pulse
  function automatic logic dtb_parity(input logic [9:0] v, input logic odd,
                                      input logic all);
    logic [9:0] m;
    m = all ? v : {2'b00, v[7:0]};
    return (^m) ^ odd;
  endfunction

endpackage

// >>> include/dtb_chan_if.sv
// Per-channel carrier between register top and channel engine
`timescale 1ns/1ps
interface dtb_chan_if;
  import dtb_pkg::*;
  logic en;
  logic sts1;
  logic par_odd;
  logic par_all;
  logic link_clk;
  logic [DTB_DATA_W-1:0] src_data;
  logic src_toh;
  logic src_c1;
  logic src_j1;
  logic src_ais;
  logic src_take;
  logic bus_clk;
  logic [DTB_DATA_W-1:0] bus_data;
  logic pl;
  logic phase;
  logic parity;
  logic alarm;
  logic ev_ais;
  logic ev_frame;
  logic frame_seen;

  modport top (
    output en, sts1, par_odd, par_all, link_clk,
    output src_data, src_toh, src_c1, src_j1, src_ais,
    input src_take, bus_clk, bus_data, pl, phase, parity, alarm,
    input ev_ais, ev_frame, frame_seen
  );
  modport chan (
    input en, sts1, par_odd, par_all, link_clk,
    input src_data, src_toh, src_c1, src_j1, src_ais,
    output src_take, bus_clk, bus_data, pl, phase, parity, alarm,
    output ev_ais, ev_frame, frame_seen
  );
endinterface

// >>> logic/dtb_chan.sv
// Channel engine: link clock recovery, bus clock and byte launch
`timescale 1ns/1ps
module dtb_chan (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  dtb_chan_if.chan ch     // Channel carrier
);
  import dtb_pkg::*;

  logic lclk_meta_reg;
  logic lclk_sync_reg;
  logic lclk_prev_reg;
  logic [1:0] div_reg;
  logic lrise;
  logic lfall;
  logic tick;
  logic frame_seen_reg;
  logic live;
  logic pl_next;
  logic phase_next;
  logic alarm_next;
  logic bus_clk_reg;
  logic [DTB_DATA_W-1:0] data_reg;
  logic pl_reg;
  logic phase_reg;
  logic par_reg;
  logic alarm_reg;
  logic ev_ais_reg;
  logic ev_frame_reg;

  // ----------------------------------------
  // Link clock sampling
  // ----------------------------------------
  // Two stages before any edge logic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lclk_meta_reg <= 1'b0;
      lclk_sync_reg <= 1'b0;
      lclk_prev_reg <= 1'b0;
    end else begin
      lclk_meta_reg <= ch.link_clk;
      lclk_sync_reg <= lclk_meta_reg;
      lclk_prev_reg <= lclk_sync_reg;
    end
  end

  assign lrise = lclk_sync_reg & ~lclk_prev_reg;
  assign lfall = ~lclk_sync_reg & lclk_prev_reg;

  // R2 - rate divider
  always_ff @(posedge clk_i) begin
    if (rst_i || !ch.en || !ch.sts1) begin
      div_reg <= 2'd0;
    end else if (lrise) begin
      div_reg <= (div_reg == DTB_DIV_LAST) ? 2'd0 : 2'(div_reg + 2'd1);
    end
  end

  // One launch per bus clock period
  assign tick = ch.en & lrise & (div_reg == 2'd0);

  // R2 - bus clock output
  always_ff @(posedge clk_i) begin
    if (rst_i || !ch.en) begin
      bus_clk_reg <= 1'b0;
    end else if (tick) begin
      bus_clk_reg <= 1'b1;
    end else if (lfall && (div_reg == 2'd0 || div_reg == DTB_DIV_LAST)) begin
      bus_clk_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Byte launch
  // ----------------------------------------
  // R15 - quiet until first C1
  always_ff @(posedge clk_i) begin
    if (rst_i || !ch.en) begin
      frame_seen_reg <= 1'b0;
    end else if (tick && ch.src_c1) begin
      frame_seen_reg <= 1'b1;
    end
  end

  assign live = frame_seen_reg | ch.src_c1;
  // R3 R4 R5 R6 - indicator and phase
  assign pl_next = live & ~ch.src_c1 & (ch.src_j1 | ~ch.src_toh);
  assign phase_next = live & (ch.src_c1 | ch.src_j1);
  // R10 - alarm follows path AIS
  assign alarm_next = live & ch.src_ais;

  // R1 R11 R12 - all outputs launched with the clock rise
  always_ff @(posedge clk_i) begin
    if (rst_i || !ch.en) begin
      data_reg <= '0;
      pl_reg <= 1'b0;
      phase_reg <= 1'b0;
      alarm_reg <= 1'b0;
      par_reg <= 1'b0;
    end else if (tick) begin
      data_reg <= ch.src_data;
      pl_reg <= pl_next;
      phase_reg <= phase_next;
      alarm_reg <= alarm_next;
      // R7 R8 - parity sense and coverage
      par_reg <= dtb_parity({pl_next, phase_next, ch.src_data}, ch.par_odd, ch.par_all);
    end
  end

  // Event pulses for the status register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ev_ais_reg <= 1'b0;
      ev_frame_reg <= 1'b0;
    end else begin
      ev_ais_reg <= tick & alarm_next & ~alarm_reg;
      ev_frame_reg <= tick & ch.src_c1;
    end
  end

  // Outputs to the top
  assign ch.src_take = tick;
  assign ch.bus_clk = bus_clk_reg;
  assign ch.bus_data = data_reg;
  assign ch.pl = pl_reg;
  assign ch.phase = phase_reg;
  assign ch.parity = par_reg;
  assign ch.alarm = alarm_reg;
  assign ch.ev_ais = ev_ais_reg;
  assign ch.ev_frame = ev_frame_reg;
  assign ch.frame_seen = frame_seen_reg;

endmodule

// >>> logic/dtb_drop_port.sv
// Three-channel drop telecom bus output port with Wishbone registers
//
// Notes on behaviour
// R1 - Every drop bus output changes together with the rise of that channel's bus clock.
// R2 - The bus clock runs at the STS-3 rate, or at a third of it in STS-1 mode.
// R3 - The payload indicator is low for the whole period of a transport overhead byte.
// R4 - The payload indicator is high for every period carrying a non-overhead byte.
// R5 - C1 is marked by a one-period phase pulse with the payload indicator low.
// R6 - J1 is marked by a one-period phase pulse with the payload indicator high.
// R7 - Parity may cover the eight data bits only, even or odd as chosen.
// R8 - Parity may instead also cover the payload indicator and the phase pulse.
// R9 - Parity sense and coverage are chosen in the bus control register.
// R10 - The alarm output is high with data carrying path AIS and low otherwise.
// R11 - The data bus is eight bits wide with bit 0 as least significant.
// R12 - Bit 7 of the data bus is the most significant bit.
// R13 - The pins carry the bus only while the channel is enabled, else the alternate function.
// R14 - Three independent channels each have their own full set of outputs.
// R15 - After reset the indicator, phase pulse and alarm stay low until a frame starts.
`timescale 1ns/1ps
module dtb_drop_port (
  input wire logic clk_i,                                    // System clock
  input wire logic rst_i,                                    // Synchronous reset
  input wire logic wb_cyc_i,                                 // Bus cycle
  input wire logic wb_stb_i,                                 // Strobe
  input wire logic wb_we_i,                                  // Write enable
  input wire logic [dtb_pkg::DTB_WB_ADR_W-1:0] wb_adr_i,     // Byte address
  input wire logic [3:0] wb_sel_i,                           // Byte lanes
  input wire logic [31:0] wb_dat_i,                          // Write data
  output logic [31:0] wb_dat_o,                              // Read data
  output logic wb_ack_o,                                     // Acknowledge
  output logic irq_o,                                        // Interrupt level
  input wire logic [dtb_pkg::DTB_CHANNELS-1:0] drop_link_clk_i,  // Byte-rate link clock
  input wire logic [dtb_pkg::DTB_CHANNELS-1:0][7:0] src_data_i,  // Next byte
  input wire logic [dtb_pkg::DTB_CHANNELS-1:0] src_toh_i,    // Next byte is overhead
  input wire logic [dtb_pkg::DTB_CHANNELS-1:0] src_c1_i,     // Next byte is C1
  input wire logic [dtb_pkg::DTB_CHANNELS-1:0] src_j1_i,     // Next byte is J1
  input wire logic [dtb_pkg::DTB_CHANNELS-1:0] src_ais_i,    // Next byte under path AIS
  output logic [dtb_pkg::DTB_CHANNELS-1:0] src_take_o,       // Byte taken pulse
  input wire logic [dtb_pkg::DTB_CHANNELS-1:0] alt_clock_i,  // Alternate clock pin value
  input wire logic [dtb_pkg::DTB_CHANNELS-1:0][7:0] alt_data_i,  // Alternate data pins
  input wire logic [dtb_pkg::DTB_CHANNELS-1:0][3:0] alt_misc_i,  // Alternate indicator pins
  output logic [dtb_pkg::DTB_CHANNELS-1:0] drop_bus_clock_o,     // Bus clock
  output logic [dtb_pkg::DTB_CHANNELS-1:0][7:0] drop_bus_data_o, // Bus data
  output logic [dtb_pkg::DTB_CHANNELS-1:0] payload_indicator_o,  // Payload indicator
  output logic [dtb_pkg::DTB_CHANNELS-1:0] frame_phase_pulse_o,  // C1/J1 phase pulse
  output logic [dtb_pkg::DTB_CHANNELS-1:0] drop_bus_parity_o,    // Parity
  output logic [dtb_pkg::DTB_CHANNELS-1:0] path_ais_alarm_o      // Path AIS alarm
);
  import dtb_pkg::*;

  logic [7:0] ctrl_reg;
  logic [7:0] cfg_reg;
  logic [7:0] stat_reg;
  logic [7:0] mask_reg;
  logic [7:0] stat_next;
  logic [7:0] live_state;
  logic [7:0] rd_mux;
  logic [31:0] rdata_reg;
  logic ack_reg;
  logic req;
  logic wr_lane0;
  logic [9:0] idx;
  logic [DTB_CHANNELS-1:0] ev_ais;
  logic [DTB_CHANNELS-1:0] ev_frame;
  logic [DTB_CHANNELS-1:0] alarm_now;
  logic [DTB_CHANNELS-1:0] seen_now;

  dtb_chan_if ch[DTB_CHANNELS] ();

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  // New request, not yet answered
  assign req = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wr_lane0 = req & wb_we_i & wb_sel_i[0];
  assign idx = wb_adr_i[DTB_WB_ADR_W-1:2];

  // Acknowledge one cycle after the request, drop the next
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req;
    end
  end

  // R9 - parity selection register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= DTB_CTRL_RESET;
    end else if (wr_lane0 && idx == DTB_IDX_BUS_CTRL) begin
      ctrl_reg <= wb_dat_i[7:0];
    end
  end

  // R13 - channel enable and mode register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_reg <= DTB_CFG_RESET;
    end else if (wr_lane0 && idx == DTB_IDX_CHAN_CFG) begin
      cfg_reg <= wb_dat_i[7:0];
    end
  end

  // Interrupt mask
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_reg <= DTB_MASK_RESET;
    end else if (wr_lane0 && idx == DTB_IDX_IRQ_MASK) begin
      mask_reg <= wb_dat_i[7:0];
    end
  end

  // Sticky status: write one clears, a new event wins over the clear
  always_comb begin
    stat_next = stat_reg;
    if (wr_lane0 && idx == DTB_IDX_IRQ_STAT) begin
      stat_next = stat_reg & ~wb_dat_i[7:0];
    end
    stat_next[DTB_EV_AIS_LSB +: DTB_CHANNELS] =
      stat_next[DTB_EV_AIS_LSB +: DTB_CHANNELS] | ev_ais;
    stat_next[DTB_EV_FRAME_LSB +: DTB_CHANNELS] =
      stat_next[DTB_EV_FRAME_LSB +: DTB_CHANNELS] | ev_frame;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_reg <= DTB_STAT_RESET;
    end else begin
      stat_reg <= stat_next;
    end
  end

  // Interrupt level from unmasked status
  assign irq_o = |(stat_reg & mask_reg);

  // Live state view
  always_comb begin
    live_state = 8'h00;
    live_state[DTB_EV_AIS_LSB +: DTB_CHANNELS] = alarm_now;
    live_state[DTB_EV_FRAME_LSB +: DTB_CHANNELS] = seen_now;
  end

  // Read decode, unmapped reads as zero
  always_comb begin
    unique case (idx)
      DTB_IDX_BUS_CTRL: rd_mux = ctrl_reg;
      DTB_IDX_CHAN_CFG: rd_mux = cfg_reg;
      DTB_IDX_IRQ_STAT: rd_mux = stat_reg;
      DTB_IDX_IRQ_MASK: rd_mux = mask_reg;
      DTB_IDX_LIVE: rd_mux = live_state;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (req) begin
      rdata_reg <= {24'h00_0000, rd_mux};
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  // ----------------------------------------
  // Channels
  // ----------------------------------------
  // R14 - three independent channels
  for (genvar g = 0; g < DTB_CHANNELS; g++) begin : g_chan
    logic en;

    assign en = cfg_reg[DTB_CFG_EN_LSB + g];
    assign ch[g].en = en;
    assign ch[g].sts1 = cfg_reg[DTB_CFG_STS1_LSB + g];
    assign ch[g].par_odd = ctrl_reg[DTB_CTRL_ODD_BIT];
    assign ch[g].par_all = ctrl_reg[DTB_CTRL_ALL_BIT];
    assign ch[g].link_clk = drop_link_clk_i[g];
    assign ch[g].src_data = src_data_i[g];
    assign ch[g].src_toh = src_toh_i[g];
    assign ch[g].src_c1 = src_c1_i[g];
    assign ch[g].src_j1 = src_j1_i[g];
    assign ch[g].src_ais = src_ais_i[g];

    dtb_chan u_chan (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .ch (ch[g])
    );

    assign src_take_o[g] = ch[g].src_take;
    assign ev_ais[g] = ch[g].ev_ais;
    assign ev_frame[g] = ch[g].ev_frame;
    assign alarm_now[g] = ch[g].alarm;
    assign seen_now[g] = ch[g].frame_seen;

    // R13 - pins carry alternate function while disabled
    assign drop_bus_clock_o[g] = en ? ch[g].bus_clk : alt_clock_i[g];
    assign drop_bus_data_o[g] = en ? ch[g].bus_data : alt_data_i[g];
    assign payload_indicator_o[g] = en ? ch[g].pl : alt_misc_i[g][0];
    assign frame_phase_pulse_o[g] = en ? ch[g].phase : alt_misc_i[g][1];
    assign drop_bus_parity_o[g] = en ? ch[g].parity : alt_misc_i[g][2];
    assign path_ais_alarm_o[g] = en ? ch[g].alarm : alt_misc_i[g][3];
  end

endmodule

// >>> dv/dtb_drop_port_monitor.sv
// Concurrent checks on channel 0 of the drop telecom bus port
`timescale 1ns/1ps
module dtb_drop_port_monitor
  import dtb_pkg::*;
(
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_we_i, // Write
  input wire logic [dtb_pkg::DTB_WB_ADR_W-1:0] wb_adr_i, // Address
  input wire logic [3:0] wb_sel_i, // Lanes
  input wire logic [31:0] wb_dat_i, // Write data
  input wire logic wb_ack_o, // Ack
  input wire logic [dtb_pkg::DTB_CHANNELS-1:0][7:0] src_data_i, // Byte
  input wire logic [dtb_pkg::DTB_CHANNELS-1:0] src_toh_i, // Overhead
  input wire logic [dtb_pkg::DTB_CHANNELS-1:0] src_c1_i, // C1
  input wire logic [dtb_pkg::DTB_CHANNELS-1:0] src_j1_i, // J1
  input wire logic [dtb_pkg::DTB_CHANNELS-1:0] src_ais_i, // AIS
  input wire logic [dtb_pkg::DTB_CHANNELS-1:0] src_take_o, // Take
  input wire logic [dtb_pkg::DTB_CHANNELS-1:0] alt_clock_i, // Alt clock
  input wire logic [dtb_pkg::DTB_CHANNELS-1:0][7:0] alt_data_i, // Alt data
  input wire logic [dtb_pkg::DTB_CHANNELS-1:0][3:0] alt_misc_i, // Alt misc
  input wire logic [dtb_pkg::DTB_CHANNELS-1:0] drop_bus_clock_o, // Bus clock
  input wire logic [dtb_pkg::DTB_CHANNELS-1:0][7:0] drop_bus_data_o, // Data
  input wire logic [dtb_pkg::DTB_CHANNELS-1:0] payload_indicator_o, // Indicator
  input wire logic [dtb_pkg::DTB_CHANNELS-1:0] frame_phase_pulse_o, // Phase
  input wire logic [dtb_pkg::DTB_CHANNELS-1:0] drop_bus_parity_o, // Parity
  input wire logic [dtb_pkg::DTB_CHANNELS-1:0] path_ais_alarm_o // Alarm
);
  logic en_reg, seen_reg, wr_take, gate, bclk, pl, ph, exp_pl, exp_ph;
  logic [1:0] ctl_reg, ctl_old;
  // ----------------------------------------
  // Register snoop
  // ----------------------------------------
  // Shadow of enable, parity select and frame start
  assign wr_take = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & ~wb_ack_o;
  assign gate = seen_reg | src_c1_i[0];
  assign bclk = drop_bus_clock_o[0];
  assign pl = payload_indicator_o[0];
  assign ph = frame_phase_pulse_o[0];
  assign exp_pl = src_j1_i[0] | ~(src_toh_i[0] | src_c1_i[0]);
  assign exp_ph = src_c1_i[0] | src_j1_i[0];
  always_ff @(posedge clk_i) begin
    if (rst_i) ctl_reg <= 2'h0;
    else if (wr_take && wb_adr_i[11:2] == DTB_IDX_BUS_CTRL) ctl_reg <= wb_dat_i[1:0];
  end
  always_ff @(posedge clk_i) ctl_old <= ctl_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) en_reg <= 1'b0;
    else if (wr_take && wb_adr_i[11:2] == DTB_IDX_CHAN_CFG) en_reg <= wb_dat_i[0];
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || !en_reg) seen_reg <= 1'b0;
    else if (src_take_o[0] && src_c1_i[0]) seen_reg <= 1'b1;
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wb_ack_a:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("Bus ack not a one-cycle answer");
  launch_take_a:
    assert property (src_take_o[0] && en_reg ##1 en_reg |-> $rose(bclk)
      && drop_bus_data_o[0] == $past(src_data_i[0]))
    else $error("Byte not launched with bus clock rise");
  stable_hold_a:
    assert property (en_reg && $past(en_reg) && !$rose(bclk) |-> $stable(drop_bus_data_o[0])
      && $stable(pl) && $stable(ph) && $stable(drop_bus_parity_o[0])
      && $stable(path_ais_alarm_o[0]))
    else $error("Output moved without bus clock rise");
  pl_map_a:
    assert property (src_take_o[0] && en_reg && gate ##1 en_reg |-> pl == $past(exp_pl))
    else $error("Payload indicator wrong");
  phase_map_a:
    assert property (src_take_o[0] && en_reg && gate ##1 en_reg |-> ph == $past(exp_ph))
    else $error("Phase pulse wrong");
  alarm_map_a:
    assert property (src_take_o[0] && en_reg && gate ##1 en_reg
      |-> path_ais_alarm_o[0] == $past(src_ais_i[0]))
    else $error("Alarm does not follow path AIS");
  quiet_start_a:
    assert property (src_take_o[0] && en_reg && !gate ##1 en_reg
      |-> !(pl || ph || path_ais_alarm_o[0]))
    else $error("Indicators active before frame");
  parity_sel_a:
    assert property (en_reg && $past(en_reg) && $rose(bclk) |-> drop_bus_parity_o[0]
      == (^drop_bus_data_o[0] ^ ctl_old[0] ^ (ctl_old[1] & (pl ^ ph))))
    else $error("Parity bit wrong");
  alt_pass_a:
    assert property (!en_reg |-> bclk == alt_clock_i[0] && drop_bus_data_o[0] == alt_data_i[0]
      && {path_ais_alarm_o[0], drop_bus_parity_o[0], ph, pl} == alt_misc_i[0])
    else $error("Alternate pins not passed");
  cover property (src_take_o[0] && src_j1_i[0] && en_reg);
  cover property (path_ais_alarm_o[0] && en_reg);
  cover property ($rose(bclk) && ctl_old == 2'h3);
endmodule

bind dtb_drop_port dtb_drop_port_monitor u_mon (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .src_data_i, .src_toh_i, .src_c1_i,
  .src_j1_i, .src_ais_i, .src_take_o, .alt_clock_i, .alt_data_i, .alt_misc_i,
  .drop_bus_clock_o, .drop_bus_data_o, .payload_indicator_o, .frame_phase_pulse_o,
  .drop_bus_parity_o, .path_ais_alarm_o);

// >>> dv/dtb_drop_rx_model.sv
// Drop-side receiver that samples the bus and checks its parity
`timescale 1ns/1ps
module dtb_drop_rx_model (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic bus_clock_i, // Bus clock
  input wire logic [7:0] bus_data_i, // Data
  input wire logic pl_i, // Payload indicator
  input wire logic phase_i, // Phase pulse
  input wire logic parity_i, // Parity
  input wire logic odd_i, // Odd sense
  input wire logic all_i, // Wide coverage
  output logic [15:0] c1_cnt_o, // C1 marks
  output logic [15:0] j1_cnt_o, // J1 marks
  output logic [15:0] perr_cnt_o // Parity faults
);
  logic prev_reg, exp_par;
  assign exp_par = (^bus_data_i) ^ odd_i ^ (all_i & (pl_i ^ phase_i));
  // Bus clock edge finder, high in reset so idle pins give no edge
  always_ff @(posedge clk_i) prev_reg <= rst_i ? 1'b1 : bus_clock_i;
  // Sample each byte on the bus clock rise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      c1_cnt_o <= 16'h0000;
      j1_cnt_o <= 16'h0000;
      perr_cnt_o <= 16'h0000;
    end else if (bus_clock_i && !prev_reg) begin
      if (parity_i !== exp_par) perr_cnt_o <= perr_cnt_o + 16'h0001;
      if (phase_i && !pl_i) c1_cnt_o <= c1_cnt_o + 16'h0001;
      if (phase_i && pl_i) j1_cnt_o <= j1_cnt_o + 16'h0001;
    end
  end
endmodule

// >>> dv/test_dtb_drop_port.sv
// Self-checking bench for the drop telecom bus port
`timescale 1ns/1ps
module test_dtb_drop_port;
  import dtb_pkg::*;
  `define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fail_count++; \
    $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end
  localparam logic [11:0] A_CTRL = {DTB_IDX_BUS_CTRL, 2'b00};
  localparam logic [11:0] A_CFG = {DTB_IDX_CHAN_CFG, 2'b00};
  localparam logic [11:0] A_STAT = {DTB_IDX_IRQ_STAT, 2'b00};
  localparam logic [11:0] A_MASK = {DTB_IDX_IRQ_MASK, 2'b00};
  localparam int LINK_CYC = 16;
  int fail_count = 0, n_compared = 0;
  logic clk_i = 1'b0, rst_i = 1'b1, lclk = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [31:0] dat = 32'h0000_0000, wb_dat_o;
  logic wb_ack_o, irq_o;
  logic [1:0] par_sel = 2'h0;
  logic [2:0] k [3];
  logic [2:0] ais_on = 3'h0, src_toh, src_c1, src_j1, src_take_o, alt_clock = 3'h5;
  logic [2:0][7:0] src_data, alt_data = {8'hC3, 8'h81, 8'h7E}, drop_bus_data_o;
  logic [2:0][3:0] alt_misc = {4'hA, 4'h5, 4'h3};
  logic [2:0] drop_bus_clock_o, payload_indicator_o, frame_phase_pulse_o;
  logic [2:0] drop_bus_parity_o, path_ais_alarm_o;
  logic [15:0] c1_cnt, j1_cnt, perr_cnt;
  // ----------------------------------------
  // Clocks, source frames and instances
  // ----------------------------------------
  initial forever #5 clk_i = ~clk_i;
  initial begin
    #3;
    forever #80 lclk = ~lclk;
  end
  // Eight-byte frame: C1, two overhead, J1, payload
  always_comb begin
    for (int c = 0; c < 3; c++) begin
      src_data[c] = {k[c], ~k[c], 2'(c)};
      src_toh[c] = (k[c] < 3'h3);
      src_c1[c] = (k[c] == 3'h0);
      src_j1[c] = (k[c] == 3'h3);
    end
  end
  always @(posedge clk_i) begin
    for (int c = 0; c < 3; c++) k[c] <= rst_i ? 3'h5 : k[c] + 3'(src_take_o[c] === 1'b1);
  end
  dtb_drop_port u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .irq_o(irq_o), .drop_link_clk_i({3{lclk}}), .src_data_i(src_data),
    .src_toh_i(src_toh), .src_c1_i(src_c1), .src_j1_i(src_j1), .src_ais_i(ais_on),
    .src_take_o(src_take_o), .alt_clock_i(alt_clock), .alt_data_i(alt_data),
    .alt_misc_i(alt_misc), .drop_bus_clock_o(drop_bus_clock_o),
    .drop_bus_data_o(drop_bus_data_o), .payload_indicator_o(payload_indicator_o),
    .frame_phase_pulse_o(frame_phase_pulse_o), .drop_bus_parity_o(drop_bus_parity_o),
    .path_ais_alarm_o(path_ais_alarm_o));
  dtb_drop_rx_model u_rx (.clk_i(clk_i), .rst_i(rst_i), .bus_clock_i(drop_bus_clock_o[0]),
    .bus_data_i(drop_bus_data_o[0]), .pl_i(payload_indicator_o[0]),
    .phase_i(frame_phase_pulse_o[0]), .parity_i(drop_bus_parity_o[0]), .odd_i(par_sel[0]),
    .all_i(par_sel[1]), .c1_cnt_o(c1_cnt), .j1_cnt_o(j1_cnt), .perr_cnt_o(perr_cnt));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic end_sim();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic timeout();
    fail_count++;
    $display("Error t=%0t wait limit reached", $time);
    end_sim();
  endtask
  // One classic Wishbone cycle, held until ack
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int i;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    if (i == 20) timeout();
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  // Cycles up to the next bus clock rise
  task automatic wait_rise(input int c, output int n);
    logic p;
    p = drop_bus_clock_o[c];
    for (n = 1; n <= 200; n++) begin
      @(negedge clk_i);
      if (p === 1'b0 && drop_bus_clock_o[c] === 1'b1) break;
      p = drop_bus_clock_o[c];
    end
    if (n > 200) timeout();
  endtask
  task automatic t_regs();
    logic [31:0] q;
    wb(1'b0, A_CTRL, 32'h0000_0000, q); `CHK(q, 32'h0000_0000)
    wb(1'b0, 12'h000, 32'h0000_0000, q); `CHK(q, 32'h0000_0000)
    wb(1'b1, A_CTRL, 32'h0000_0003, q);
    wb(1'b0, A_CTRL, 32'h0000_0000, q); `CHK(q, 32'h0000_0003)
  endtask
  task automatic t_alt();
    repeat (2) @(negedge clk_i);
    for (int c = 0; c < 3; c++) begin
      `CHK(drop_bus_data_o[c], alt_data[c])
      `CHK(drop_bus_clock_o[c], alt_clock[c])
      `CHK({path_ais_alarm_o[c], drop_bus_parity_o[c], frame_phase_pulse_o[c],
            payload_indicator_o[c]}, alt_misc[c])
    end
  endtask
  task automatic t_run();
    logic [31:0] q;
    logic [15:0] perr0;
    int n;
    wb(1'b1, A_CFG, 32'h0000_0007, q);
    for (int s = 0; s < 4; s++) begin
      wb(1'b1, A_CTRL, 32'(s), q);
      par_sel <= 2'(s);
      repeat (10) wait_rise(0, n);
      perr0 = perr_cnt;
      repeat (30) wait_rise(0, n);
      `CHK(perr_cnt, perr0)
    end
    `CHK(c1_cnt != 16'h0000 && j1_cnt != 16'h0000, 1'b1)
    wait_rise(1, n); `CHK(drop_bus_data_o[1][1:0], 2'h1)
    wait_rise(2, n); `CHK(drop_bus_data_o[2][1:0], 2'h2)
  endtask
  task automatic t_rate();
    logic [31:0] q;
    int n;
    repeat (2) wait_rise(0, n);
    `CHK(n, LINK_CYC)
    wb(1'b1, A_CFG, 32'h0000_0017, q);
    repeat (3) wait_rise(0, n);
    `CHK(n, LINK_CYC * DTB_STS1_DIV)
  endtask
  task automatic t_irq();
    logic [31:0] q;
    int i;
    wb(1'b1, A_STAT, 32'h0000_00FF, q);
    ais_on <= 3'h1;
    for (i = 0; i < 300 && path_ais_alarm_o[0] !== 1'b1; i++) @(negedge clk_i);
    if (i == 300) timeout();
    repeat (2) @(negedge clk_i);
    `CHK(irq_o, 1'b0)
    wb(1'b0, A_STAT, 32'h0000_0000, q); `CHK(q[0], 1'b1)
    wb(1'b0, {DTB_IDX_LIVE, 2'b00}, 32'h0000_0000, q); `CHK(q, 32'h0000_0071)
    wb(1'b1, A_MASK, 32'h0000_0001, q);
    @(negedge clk_i); `CHK(irq_o, 1'b1)
    wb(1'b1, A_STAT, 32'h0000_0001, q);
    @(negedge clk_i); `CHK(irq_o, 1'b0)
    @(posedge clk_i) ais_on <= 3'h0;
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_alt();
    t_run();
    t_rate();
    t_irq();
    end_sim();
  end
endmodule
